// ---- tec_core_model.sv ----
// Core pipeline model: takes offered events and retires them later
`timescale 1ns/1ps
module tec_core_model
  import tec_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Offer from the controller
  input wire logic core_event_req,
  input wire logic [3:0] core_event_id,
  input wire tec_evt_t core_event_active,
  // Bench control: low holds every taken event active
  input wire logic ret_en,
  // Answer to the controller
  output logic core_event_accept,
  output logic core_event_return,
  // Observation
  output logic [3:0] acc_id,
  output logic [7:0] acc_cnt
);
  logic [2:0] dly_q;
  logic take;
  assign take = core_event_req && !core_event_accept;
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      core_event_accept <= 1'b0;
      core_event_return <= 1'b0;
      acc_id <= 4'h0;
      acc_cnt <= 8'h00;
      dly_q <= 3'h0;
    end else begin
      // Pulse with a gap cycle so the offer can drop after it is taken
      core_event_accept <= take;
      if (take) begin
        acc_id <= core_event_id;
        acc_cnt <= acc_cnt + 8'h01;
      end
      // Slow retirement, so nesting can build up meanwhile
      dly_q <= (|core_event_active && !core_event_return) ?
               dly_q + 3'h1 : 3'h0;
      core_event_return <= ret_en && dly_q == 3'h7;
    end
  end
endmodule

// ---- tec_event_ctrl.sv ----
// Two-stage event controller: peripheral routing stage and core event stage
`timescale 1ns/1ps

// Contract
// - Sources 17 to 19 route to core interrupt 2 after reset.
// - Sources 20 to 25 route to core interrupt 3 after reset.
// - Sources 43 to 46 route to core interrupt 6 after reset.
// - Source 47 routes to core interrupt 0 after reset.
// - Sources 48, 51 to 55 route to core 3; 49, 50, 56-63 unrouted.
// - Core latch, enable and active registers, sixteen bits, one per event.
// - Latch bit sets on latching, clears on acceptance into the system.
// - Only enabled latched events are serviced; disabled ones stay latched.
// - Core enable register readable and writable in supervisor mode.
// - Two instructions globally enable and disable general-purpose events.
// - Active register kept by hardware, marks active or nested events.
// - Peripheral enable, status, wake registers, paired 32-bit, one bit each.
// - Peripheral requests reach the core only while their enable bit is set.
// - Status bit reads one while its peripheral asserts its request.
// - An enabled wake bit wakes the sleeping core on that request.
// - Peripheral stage takes the core active register as acknowledgement; here it takes none, request and status follow the pin.
// - Rising edge on a core input sets its latch bit in two cycles.
// - Latch clears when active sets; next rising edge is then queued.
// - At least three cycles from input rising edge to active bit.
// - Software can change routing and priority via assignment registers.
// - Higher priority first; nesting lets several routines be active.
module tec_event_ctrl
  import tec_pkg::*;
(
  // Clock, reset, enable
  input wire logic mclk,
  input wire logic resetn,
  input wire logic clk_en,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [2:0] pprot,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // Peripheral request pins
  input wire logic [N_SRC-1:0] periph_req,
  // Core pipeline
  input wire logic global_int_on_instr,
  input wire logic global_int_off_instr,
  input wire logic core_event_accept,
  input wire logic core_event_return,
  output logic core_event_req,
  output logic [3:0] core_event_id,
  output tec_evt_t core_event_active,
  // Power management
  output logic core_wake_req
);

  // Highest eligible event: lowest index wins, and an active event of equal
  // or higher priority blocks everything below it.
  function automatic logic [4:0] pick_event(input tec_evt_t lat,
                                            input tec_evt_t msk,
                                            input tec_evt_t pnd,
                                            input logic gie);
    tec_evt_t cand;
    logic found;
    logic blk;
    logic [3:0] id;
    cand = lat & msk & GP_BITS & {N_EVT{gie}};
    found = 1'b0;
    blk = 1'b0;
    id = 4'h0;
    for (int i = 0; i < N_EVT; i++) begin
      if (!found && !blk) begin
        if (pnd[i]) begin
          blk = 1'b1;
        end else if (cand[i]) begin
          found = 1'b1;
          id = 4'(i);
        end
      end
    end
    return {found, id};
  endfunction

  // Pin synchroniser, three stages with agreement filter
  logic [N_SRC-1:0] sync1_q, sync2_q, sync3_q;
  logic [N_SRC-1:0] filt_q;
  wire [N_SRC-1:0] filt_d = (sync2_q & sync3_q) |
                            (filt_q & (sync2_q | sync3_q));

  // Peripheral stage registers
  logic [N_SRC-1:0] pen_q;
  logic [N_SRC-1:0] pwk_q;
  logic [DATA_W-1:0] asgn_q [N_ASGN];
  logic wake_q;

  // Core stage registers
  tec_evt_t latch_q, latch_d;
  tec_evt_t mask_q, mask_d;
  tec_evt_t pend_q, pend_d;
  logic gie_q, gie_d;
  logic [N_GP-1:0] gp_q, gp_prev_q;
  logic req_q;
  logic [3:0] id_q;

  // APB state
  logic ready_q;
  logic [DATA_W-1:0] rdata_q;
  logic err_q;

  wire [N_SRC-1:0] masked = filt_q & pen_q;
  logic [N_GP-1:0] gp_in;

  // Routing: a source whose code is above the last input is dropped
  always_comb begin
    gp_in = '0;
    for (int s = 0; s < N_SRC; s++) begin
      for (int k = 0; k < N_GP; k++) begin
        if (asgn_q[s / SRC_PER_ASGN][(s % SRC_PER_ASGN) * ASGN_W +: ASGN_W]
            == ASGN_W'(k)) begin
          gp_in[k] = gp_in[k] | masked[s];
        end
      end
    end
  end

  // Edge detect over two registered samples
  wire [N_GP-1:0] gp_rise = gp_q & ~gp_prev_q;
  wire tec_evt_t edge_vec = {gp_rise, {GP_LO{1'b0}}};

  // APB decode
  wire apb_cap = psel & penable & ~ready_q;
  wire apb_done = psel & penable & ready_q;
  wire priv = pprot[PROT_PRIV_BIT];
  wire [ADDR_W-1:0] asgn_off = paddr - OFF_ASGN;
  wire [2:0] asgn_idx = asgn_off[WORD_LSB +: 3];
  wire hit_asgn = (paddr >= OFF_ASGN) && (paddr < OFF_GIE) &&
                  (paddr[WORD_LSB-1:0] == 2'b00);
  wire hit_core = (paddr == OFF_LATCH) || (paddr == OFF_ENABLE) ||
                  (paddr == OFF_ACTIVE);
  wire hit = hit_core || hit_asgn || (paddr == OFF_PEN0) ||
             (paddr == OFF_PEN1) || (paddr == OFF_PST0) ||
             (paddr == OFF_PST1) || (paddr == OFF_PWK0) ||
             (paddr == OFF_PWK1) || (paddr == OFF_GIE);
  // Core registers need supervisor privilege
  wire err_w = !hit || (hit_core && !priv);
  wire wr_ok = apb_done && pwrite && !err_q && clk_en;
  wire wr_latch = wr_ok && (paddr == OFF_LATCH);
  wire wr_mask = wr_ok && (paddr == OFF_ENABLE);

  logic [DATA_W-1:0] rdata_w;
  always_comb begin
    rdata_w = WORD_RST;
    case (paddr)
      OFF_LATCH: rdata_w = {16'h0000, latch_q};
      OFF_ENABLE: rdata_w = {16'h0000, mask_q};
      OFF_ACTIVE: rdata_w = {16'h0000, pend_q};
      OFF_PEN0: rdata_w = pen_q[DATA_W-1:0];
      OFF_PEN1: rdata_w = pen_q[N_SRC-1:DATA_W];
      OFF_PST0: rdata_w = filt_q[DATA_W-1:0];
      OFF_PST1: rdata_w = filt_q[N_SRC-1:DATA_W];
      OFF_PWK0: rdata_w = pwk_q[DATA_W-1:0];
      OFF_PWK1: rdata_w = pwk_q[N_SRC-1:DATA_W];
      OFF_GIE: rdata_w = {31'h0000_0000, gie_q};
      default: begin
        if (hit_asgn) begin
          rdata_w = asgn_q[asgn_idx];
        end
      end
    endcase
    if (err_w) begin
      rdata_w = WORD_RST;
    end
  end

  // Pipeline handshake
  wire acc = core_event_accept & req_q;
  wire tec_evt_t acc_oh = acc ? tec_evt_t'(ONE16 << id_q) : EVT_RST;
  // Return retires the most deeply nested (highest priority) active event
  wire tec_evt_t ret_oh = core_event_return ?
                          (pend_q & tec_evt_t'(~pend_q + ONE16)) : EVT_RST;

  always_comb begin
    latch_d = latch_q;
    if (wr_latch) begin
      // Enabled bits stay under hardware control
      latch_d = (latch_q & mask_q) | (pwdata[N_EVT-1:0] & ~mask_q);
    end
    // Acceptance clears, a new edge in the same cycle wins
    latch_d = ((latch_d & ~acc_oh) | edge_vec) & GP_BITS;
  end

  assign mask_d = wr_mask ? (pwdata[N_EVT-1:0] & GP_BITS) : mask_q;
  // Active bit marks pipeline entry; nesting keeps older bits set
  assign pend_d = ((pend_q & ~ret_oh) | acc_oh) & GP_BITS;
  // Disable wins when both instructions arrive together
  assign gie_d = global_int_off_instr ? 1'b0 :
                 (global_int_on_instr ? 1'b1 : gie_q);

  // Request computed from next state so it never offers a consumed event
  wire [4:0] pick_d = pick_event(latch_d, mask_d, pend_d, gie_d);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
      filt_q <= '0;
    end else if (clk_en) begin
      sync1_q <= periph_req;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
      filt_q <= filt_d;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pen_q <= '0;
      pwk_q <= '0;
      wake_q <= 1'b0;
      for (int j = 0; j < N_ASGN; j++) begin
        asgn_q[j] <= ASGN_RST[j];
      end
    end else if (clk_en) begin
      wake_q <= |(filt_q & pwk_q);
      if (wr_ok && paddr == OFF_PEN0) pen_q[DATA_W-1:0] <= pwdata;
      if (wr_ok && paddr == OFF_PEN1) pen_q[N_SRC-1:DATA_W] <= pwdata;
      if (wr_ok && paddr == OFF_PWK0) pwk_q[DATA_W-1:0] <= pwdata;
      if (wr_ok && paddr == OFF_PWK1) pwk_q[N_SRC-1:DATA_W] <= pwdata;
      if (wr_ok && hit_asgn) asgn_q[asgn_idx] <= pwdata;
    end
  end

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      latch_q <= EVT_RST;
      mask_q <= EVT_RST;
      pend_q <= EVT_RST;
      gie_q <= 1'b0;
      gp_q <= '0;
      gp_prev_q <= '0;
      req_q <= 1'b0;
      id_q <= 4'h0;
    end else if (clk_en) begin
      gp_q <= gp_in;
      gp_prev_q <= gp_q;
      latch_q <= latch_d;
      mask_q <= mask_d;
      pend_q <= pend_d;
      gie_q <= gie_d;
      req_q <= pick_d[4];
      id_q <= pick_d[3:0];
    end
  end

  // One wait state: data and error are captured on the same edge that pready rises
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ready_q <= 1'b0;
      rdata_q <= WORD_RST;
      err_q <= 1'b0;
    end else if (clk_en) begin
      ready_q <= apb_cap;
      if (apb_cap) begin
        rdata_q <= rdata_w;
        err_q <= err_w;
      end
    end
  end

  assign prdata = rdata_q;
  assign pready = ready_q;
  assign pslverr = ready_q & err_q;
  assign core_event_req = req_q;
  assign core_event_id = id_q;
  assign core_event_active = pend_q;
  assign core_wake_req = wake_q;

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);

  wire [N_EVT:0] upto = (TWO17 << id_q) - ONE17;
  wire tec_evt_t id_oh = tec_evt_t'(ONE16 << id_q);

  sequence s_apb_access;
    psel && penable && !ready_q && clk_en;
  endsequence
  sequence s_apb_complete;
    ready_q ##1 !ready_q;
  endsequence

  AST_APB_ONE_WAIT: assert property (
    s_apb_access |=> s_apb_complete)
    else $error("apb answer not after exactly one wait cycle");

  AST_USER_CORE_ERR: assert property (
    (s_apb_access and (hit_core && !priv)) |=> (pready && pslverr))
    else $error("unprivileged core register access not refused");

  AST_LATCH_ON_EDGE: assert property (
    clk_en |=> ((latch_q & $past(edge_vec)) == $past(edge_vec)))
    else $error("detected edge did not set latch bit");

  AST_ACCEPT_SETS_ACTIVE: assert property (
    (clk_en && acc) |=> ((pend_q & $past(id_oh)) != EVT_RST))
    else $error("accepted event not marked active");

  AST_ACCEPT_CLEARS_LATCH: assert property (
    (clk_en && acc && !(|(edge_vec & id_oh)))
    |=> ((latch_q & $past(id_oh)) == EVT_RST))
    else $error("latch bit not cleared on acceptance");

  AST_REQ_ENABLED: assert property (
    req_q |-> (gie_q && (mask_q & latch_q & id_oh) != EVT_RST))
    else $error("request for a masked or unlatched event");

  AST_REQ_NESTING: assert property (
    req_q |-> ((pend_q & upto[N_EVT-1:0]) == EVT_RST))
    else $error("request not above all active events");

  AST_GLOBAL_OFF: assert property (
    (clk_en && global_int_off_instr) |=> !req_q)
    else $error("request offered while globally disabled");

  AST_PERIPH_MASK: assert property (
    ((filt_q & pen_q) == '0) |-> (gp_in == '0))
    else $error("masked peripheral reached a core input");

  AST_MIN_LATENCY: assert property (
    ((pend_q & ~$past(pend_q)) != EVT_RST)
    |-> (($past(latch_q) & pend_q & ~$past(pend_q)) != EVT_RST))
    else $error("active bit set without prior latch");

  AST_WAKE: assert property (
    (clk_en && (filt_q & pwk_q) != '0) |=> core_wake_req)
    else $error("wake not raised for enabled source");

  AST_STATUS_READ: assert property (
    (s_apb_access and (paddr == OFF_PST0 && priv))
    |=> (prdata == $past(filt_q[DATA_W-1:0])))
    else $error("status read differs from request pins");

endmodule

// ---- tec_event_ctrl_tb.sv ----
// Self-checking bench for the two-stage event controller
`timescale 1ns/1ps
module tec_event_ctrl_tb
  import tec_pkg::*;
;
  logic mclk = 1'b0;
  logic resetn, clk_en, psel, penable, pwrite, pready, pslverr;
  logic [2:0] pprot;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  logic [N_SRC-1:0] periph_req;
  logic on_i, off_i, accept, ret, req, wake, ret_en, er;
  logic [3:0] id, acc_id;
  logic [7:0] acc_cnt, n0;
  tec_evt_t active;
  int n_errors = 0;
  int n_tests = 0;
  int cyc;
  always #4 mclk = ~mclk;
  tec_event_ctrl tec_event_ctrl_i (.mclk(mclk), .resetn(resetn),
    .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pprot(pprot), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .periph_req(periph_req),
    .global_int_on_instr(on_i), .global_int_off_instr(off_i),
    .core_event_accept(accept), .core_event_return(ret),
    .core_event_req(req), .core_event_id(id),
    .core_event_active(active), .core_wake_req(wake));
  tec_core_model tec_core_model_i (.mclk(mclk), .resetn(resetn),
    .core_event_req(req), .core_event_id(id), .core_event_active(active),
    .ret_en(ret_en), .core_event_accept(accept), .core_event_return(ret),
    .acc_id(acc_id), .acc_cnt(acc_cnt));
  task automatic results;
    $display("Comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic p);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pprot <= {2'b00, p};
    @(posedge mclk);
    penable <= 1'b1;
    // Hold the request until pready is seen; only the watchdog ends a hang
    @(posedge mclk);
    while (pready !== 1'b1) @(posedge mclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000, 1'b1);
    chk({31'h0000_0000, er}, 32'h0000_0000);
    chk(rd, exp);
  endtask
  task automatic wait_act(input int b);
    cyc = 0;
    while (active[b] !== 1'b1 && cyc < 40) begin
      @(posedge mclk);
      cyc++;
    end
    chk(32'(active[b]), 32'h0000_0001);
  endtask
  task automatic drain;
    // Drop all requests and let the model retire what it holds
    periph_req <= '0;
    for (int i = 0; i < 100 && active !== 16'h0000; i++) @(posedge mclk);
    chk(32'(active), 32'h0000_0000);
    repeat (8) @(posedge mclk);
  endtask
  task automatic instr(input logic on);
    @(posedge mclk);
    on_i <= on;
    off_i <= !on;
    @(posedge mclk);
    on_i <= 1'b0;
    off_i <= 1'b0;
  endtask
  initial begin
    repeat (20000) @(posedge mclk);
    n_errors++;
    results();
  end
  initial begin
    {resetn, psel, penable, pwrite, on_i, off_i} = '0;
    {pprot, paddr, pwdata, periph_req} = '0;
    clk_en = 1'b1;
    ret_en = 1'b1;
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    rchk(OFF_ASGN + 8'h08, 32'h3333_2222);
    rchk(OFF_ASGN + 8'h0C, 32'hF444_4433);
    rchk(OFF_ASGN + 8'h14, 32'h0666_6655);
    rchk(OFF_ASGN + 8'h18, 32'h3333_3FF3);
    rchk(OFF_ACTIVE, 32'h0000_0000);
    $display("reset map done");
    apb(1'b1, OFF_ENABLE, 32'h0000_0400, 1'b0);
    chk({31'h0000_0000, er}, 32'h0000_0001);
    rchk(OFF_ENABLE, 32'h0000_0000);
    apb(1'b0, 8'h80, 32'h0000_0000, 1'b1);
    chk({31'h0000_0000, er}, 32'h0000_0001);
    apb(1'b1, OFF_PEN1, 32'hA5A5_5A5A, 1'b1);
    rchk(OFF_PEN1, 32'hA5A5_5A5A);
    apb(1'b1, OFF_PEN1, 32'h0000_0000, 1'b1);
    apb(1'b1, OFF_PST0, 32'hFFFF_FFFF, 1'b1);
    rchk(OFF_PST0, 32'h0000_0000);
    $display("access done");
    periph_req[20] <= 1'b1;
    apb(1'b1, OFF_ENABLE, 32'h0000_0400, 1'b1);
    instr(1'b1);
    rchk(OFF_PST0, 32'h0010_0000);
    rchk(OFF_GIE, 32'h0000_0001);
    chk(32'(acc_cnt), 32'h0000_0000);
    apb(1'b1, OFF_PEN0, 32'h0010_0000, 1'b1);
    wait_act(10);
    // Core input rises at the write edge; cyc counts one edge more
    chk(32'(cyc >= 4), 32'h0000_0001);
    chk(32'(acc_id), 32'h0000_000A);
    drain();
    $display("forwarding done");
    periph_req[17] <= 1'b1;
    apb(1'b1, OFF_PEN0, 32'h0012_0000, 1'b1);
    repeat (10) @(posedge mclk);
    rchk(OFF_LATCH, 32'h0000_0200);
    chk(32'(active), 32'h0000_0000);
    apb(1'b1, OFF_LATCH, 32'h0000_0000, 1'b1);
    rchk(OFF_LATCH, 32'h0000_0000);
    apb(1'b1, OFF_LATCH, 32'h0000_0200, 1'b1);
    rchk(OFF_LATCH, 32'h0000_0200);
    apb(1'b1, OFF_ENABLE, 32'h0000_0600, 1'b1);
    wait_act(9);
    rchk(OFF_LATCH, 32'h0000_0000);
    drain();
    $display("latch done");
    instr(1'b0);
    n0 = acc_cnt;
    apb(1'b1, OFF_ENABLE, 32'h0000_2680, 1'b1);
    apb(1'b1, OFF_PEN1, 32'h0000_8800, 1'b1);
    periph_req[47] <= 1'b1;
    repeat (10) @(posedge mclk);
    chk(32'(acc_cnt), 32'(n0));
    rchk(OFF_LATCH, 32'h0000_0080);
    instr(1'b1);
    wait_act(7);
    drain();
    $display("global enable done");
    ret_en <= 1'b0;
    periph_req[43] <= 1'b1;
    wait_act(13);
    periph_req[47] <= 1'b1;
    wait_act(7);
    chk(32'(active), 32'h0000_2080);
    rchk(OFF_ACTIVE, 32'h0000_2080);
    ret_en <= 1'b1;
    drain();
    $display("nesting done");
    apb(1'b1, OFF_PWK1, 32'h0000_2000, 1'b1);
    periph_req[45] <= 1'b1;
    repeat (8) @(posedge mclk);
    chk(32'(wake), 32'h0000_0001);
    apb(1'b1, OFF_PWK1, 32'h0000_0000, 1'b1);
    repeat (3) @(posedge mclk);
    chk(32'(wake), 32'h0000_0000);
    drain();
    $display("wake done");
    apb(1'b1, OFF_ASGN + 8'h08, 32'h3331_2222, 1'b1);
    apb(1'b1, OFF_ENABLE, 32'h0000_0100, 1'b1);
    // Frozen clock enable: the new request must not move anything
    clk_en <= 1'b0;
    periph_req[20] <= 1'b1;
    repeat (10) @(posedge mclk);
    chk(32'(req), 32'h0000_0000);
    chk(32'(active), 32'h0000_0000);
    clk_en <= 1'b1;
    wait_act(8);
    chk(32'(acc_id), 32'h0000_0008);
    drain();
    $display("remap done");
    results();
  end
endmodule

// ---- tec_pkg.sv ----
// Constants, register map and reset routing for the two-stage event controller
package tec_pkg;
  localparam int N_SRC = 64;
  localparam int N_GP = 9;
  localparam int N_EVT = 16;
  localparam int GP_LO = 7;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int ASGN_W = 4;
  localparam int SRC_PER_ASGN = 8;
  localparam int N_ASGN = 8;
  localparam int PROT_PRIV_BIT = 0;
  localparam int WORD_LSB = 2;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_LATCH = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_ENABLE = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_ACTIVE = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_PEN0 = 8'h0C;
  localparam logic [ADDR_W-1:0] OFF_PEN1 = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_PST0 = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_PST1 = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_PWK0 = 8'h1C;
  localparam logic [ADDR_W-1:0] OFF_PWK1 = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_ASGN = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_GIE = 8'h44;

  // Only general-purpose event bits exist in the core registers
  localparam logic [N_EVT-1:0] GP_BITS = 16'hFF80;
  localparam logic [N_EVT-1:0] EVT_RST = 16'h0000;
  localparam logic [DATA_W-1:0] WORD_RST = 32'h0000_0000;
  localparam logic [N_EVT-1:0] ONE16 = 16'h0001;
  localparam logic [N_EVT:0] TWO17 = 17'h0_0002;
  localparam logic [N_EVT:0] ONE17 = 17'h0_0001;

  // Default routing, one nibble per source, low source in low nibble.
  // Code F routes nowhere and marks reserved sources.
  localparam logic [DATA_W-1:0] ASGN_RST [N_ASGN] = '{
    32'h0000_0000, 32'h2211_F000, 32'h3333_2222, 32'hF444_4433,
    32'h5555_5555, 32'h0666_6655, 32'h3333_3FF3, 32'hFFFF_FFFF
  };

  typedef logic [N_EVT-1:0] tec_evt_t;
endpackage
